// ### msrs_dev_end.sv
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - command pulse held 0.7 s to 3 s
// - 3 s or longer hold locks module out
// - lockout cleared by fresh valid pulse only
// - power removed only after completion shows; CT_POFF removes it without waiting
// - indicator lit only on shutdown or reset
// - power stays off over 5 s
// - coupled first cpu reset unpowers module; code only enters D_DONE, power stays on
// - shutdown shows station as resetting
// - reset or restart flags peer down error
// - restart with reporting may raise station error
// - no report without all-stop and controller
// - single rack: hold bus toggle two seconds
// - multi rack: bus toggle flags peer error
// - uncoupled restart followed by first cpu reset
// - first cpu reset cannot revive shut module
module msrs_dev_end #(
	parameter int unsigned PULSE_MIN_CYC = msrs_pkg::PULSE_MIN_CYC,
	parameter int unsigned LOCKOUT_CYC   = msrs_pkg::LOCKOUT_CYC,
	parameter int unsigned SHUT_CYC      = msrs_pkg::OS_SHUT_CYC,
	parameter int unsigned BOOT_CYC      = msrs_pkg::OS_BOOT_CYC
) (
	input  wire logic       i_clk,
	input  wire logic       i_reset,
	input  wire logic       i_os_restart,
	output logic      [5:0] o_state,
	output logic            o_lockout,
	output logic      [1:0] o_width_class,
	output logic            o_bus_if_reset,
	msrs_link_if.dev        link
);
	if (PULSE_MIN_CYC < 1 || LOCKOUT_CYC <= PULSE_MIN_CYC ||
		SHUT_CYC < 1 || BOOT_CYC < 1) begin : g_bad_param
		$error("msrs_dev_end: bad timing parameters");
	end

	// ==========================================
	// state
	typedef struct packed {
		logic [msrs_pkg::DIN_W-1:0] s1;
		logic [msrs_pkg::DIN_W-1:0] s2;
		logic                       prev_cmd;
		logic                       prev_tog;
		logic                       armed;
		logic [31:0]                wcnt;
		logic [31:0]                tcnt;
		msrs_pkg::msrs_dev_state_t  st;
		logic                       lockout;
		logic                       peer_down;
		logic                       st_err;
		logic                       ind;
		logic                       done;
		logic                       resetting;
		logic                       os_ready;
		logic                       bus_rst;
		logic [1:0]                 wclass;
	} msrs_dev_regs_t;

	localparam msrs_dev_regs_t DEV_RST = '{
		st: msrs_pkg::D_OFF, wclass: msrs_pkg::WC_NONE, default: '0};

	msrs_dev_regs_t q, d;
	logic           cmd;
	logic           pwr;
	logic           cpu1;
	logic           tog;
	logic           multi;
	logic           couple;
	logic           report;
	logic           allstp;
	logic           ctrlp;
	logic           fall;
	logic           pulse_ok;
	logic           lock_hit;

	// ==========================================
	// peers see a down error unless reporting is
	// on with no all-stop and no controlling module
	function automatic logic report_allowed(
		input logic rep,
		input logic all_stop,
		input logic ctl_present
	);
		report_allowed = !rep || all_stop || ctl_present;
	endfunction

	// ==========================================
	// next state
	always_comb begin
		d = q;
		d.s1[msrs_pkg::I_CMD]    = link.shutdown_cmd;
		d.s1[msrs_pkg::I_PWR]    = link.power_on;
		d.s1[msrs_pkg::I_CPU1]   = link.cpu1_reset;
		d.s1[msrs_pkg::I_TOG]    = link.bus_toggle_reset;
		d.s1[msrs_pkg::I_MULTI]  = link.multi_cpu;
		d.s1[msrs_pkg::I_COUPLE] = link.reset_coupling_switch;
		d.s1[msrs_pkg::I_REPORT] = link.down_report_switch;
		d.s1[msrs_pkg::I_ALLSTP] = link.all_stop_sel;
		d.s1[msrs_pkg::I_CTRLP]  = link.ctrl_present;
		d.s2 = q.s1;
		cmd    = q.s2[msrs_pkg::I_CMD];
		pwr    = q.s2[msrs_pkg::I_PWR];
		cpu1   = q.s2[msrs_pkg::I_CPU1];
		tog    = q.s2[msrs_pkg::I_TOG];
		multi  = q.s2[msrs_pkg::I_MULTI];
		couple = q.s2[msrs_pkg::I_COUPLE];
		report = q.s2[msrs_pkg::I_REPORT];
		allstp = q.s2[msrs_pkg::I_ALLSTP];
		ctrlp  = q.s2[msrs_pkg::I_CTRLP];
		d.prev_cmd = cmd;
		d.prev_tog = tog;
		d.bus_rst = 1'b0;
		pulse_ok = 1'b0;
		lock_hit = 1'b0;
		fall = q.prev_cmd && !cmd;

		// ==========================================
		// command width; a hold present at power-up
		// is not counted until the line has been low
		if (!cmd)
			d.armed = 1'b1;
		if (cmd && q.armed && q.wcnt != LOCKOUT_CYC)
			d.wcnt = q.wcnt + 32'h1;
		if (cmd && q.armed && q.wcnt == LOCKOUT_CYC - 1) begin
			lock_hit = 1'b1;
			d.lockout = 1'b1;
			d.wclass = msrs_pkg::WC_LOCK;
		end
		if (fall && q.armed) begin
			if (q.wcnt < PULSE_MIN_CYC) begin
				d.wclass = msrs_pkg::WC_SHORT;
			end else if (q.wcnt < LOCKOUT_CYC) begin
				d.wclass = msrs_pkg::WC_VALID;
				pulse_ok = 1'b1;
			end
		end
		if (!cmd)
			d.wcnt = '0;

		// ==========================================
		// first cpu reset clears peer and station errors; the D_RUN branches and a multi rack toggle release below may set peer error again
		if (cpu1) begin
			d.peer_down = 1'b0;
			d.st_err = 1'b0;
		end
		// bus toggle takes effect on release
		if (q.prev_tog && !tog) begin
			if (multi)
				d.peer_down = 1'b1;
			else
				d.bus_rst = 1'b1;
		end

		// ==========================================
		// sequencer
		case (q.st)
			msrs_pkg::D_OFF: begin
				d.tcnt = '0;
				if (pwr)
					d.st = q.lockout ? msrs_pkg::D_LOCK : msrs_pkg::D_BOOT;
			end
			msrs_pkg::D_BOOT: begin
				d.tcnt = q.tcnt + 32'h1;
				if (q.tcnt == BOOT_CYC - 1) begin
					d.tcnt = '0;
					d.os_ready = 1'b1;
					d.st = msrs_pkg::D_RUN;
				end
			end
			msrs_pkg::D_RUN: begin
				d.tcnt = '0;
				if (cpu1 && multi && couple) begin
					// hard stop: os gets no chance to close down
					d.ind = 1'b1;
					d.done = 1'b1;
					d.resetting = 1'b1;
					d.os_ready = 1'b0;
					d.peer_down = multi &&
						report_allowed(report, allstp, ctrlp);
					d.st = msrs_pkg::D_DONE;
				end else if (pulse_ok || lock_hit) begin
					d.ind = 1'b1;
					d.resetting = 1'b1;
					d.os_ready = 1'b0;
					if (multi && report_allowed(report, allstp, ctrlp))
						d.peer_down = 1'b1;
					d.st = msrs_pkg::D_SHUT;
				end else if (i_os_restart) begin
					d.os_ready = 1'b0;
					if (multi && report_allowed(report, allstp, ctrlp))
						d.peer_down = 1'b1;
					if (multi && report)
						d.st_err = 1'b1;
					d.st = msrs_pkg::D_BOOT;
				end
			end
			msrs_pkg::D_SHUT: begin
				d.tcnt = q.tcnt + 32'h1;
				if (q.tcnt == SHUT_CYC - 1) begin
					d.tcnt = '0;
					d.done = 1'b1;
					d.st = msrs_pkg::D_DONE;
				end
			end
			msrs_pkg::D_DONE: begin
				// only a power cycle leaves this state
				d.tcnt = '0;
			end
			msrs_pkg::D_LOCK: begin
				d.tcnt = '0;
				if (pulse_ok) begin
					d.lockout = 1'b0;
					d.st = msrs_pkg::D_BOOT;
				end
			end
			default: begin
				d.st = msrs_pkg::D_OFF;
			end
		endcase

		// ==========================================
		// unpowered: indicator, completion, resetting and ready dark; peer and station errors and lockout survive
		if (!pwr) begin
			d.st = msrs_pkg::D_OFF;
			d.ind = 1'b0;
			d.done = 1'b0;
			d.resetting = 1'b0;
			d.os_ready = 1'b0;
			d.armed = 1'b0;
			d.wcnt = '0;
			d.lockout = q.lockout || lock_hit;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset)
			q <= DEV_RST;
		else
			q <= d;
	end

	// ==========================================
	// outputs
	assign o_state = q.st;
	assign o_lockout = q.lockout;
	assign o_width_class = q.wclass;
	assign o_bus_if_reset = q.bus_rst;
	assign link.shutdown_done = q.done;
	assign link.shutdown_done_indicator = q.ind;
	assign link.station_resetting = q.resetting;
	assign link.peer_down_error = q.peer_down;
	assign link.station_error = q.st_err;
	assign link.os_ready = q.os_ready;
endmodule // msrs_dev_end
`default_nettype wire

// ### msrs_pkg.sv
`default_nettype none
package msrs_pkg;
	// ==========================================
	// timing
	localparam int unsigned CLK_HZ         = 200_000_000;
	localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
	localparam int unsigned PULSE_MIN_MS   = 700;
	localparam int unsigned LOCKOUT_MS     = 3000;
	localparam int unsigned OFF_WAIT_MS    = 5000;
	localparam int unsigned TOGGLE_HOLD_MS = 2000;
	localparam int unsigned PULSE_HOLD_MS  = 1500;
	localparam int unsigned LOCK_HOLD_MS   = 3500;
	localparam int unsigned PULSE_MIN_CYC  = PULSE_MIN_MS * CYC_PER_MS;
	localparam int unsigned LOCKOUT_CYC    = LOCKOUT_MS * CYC_PER_MS;
	// strictly longer than the off time
	localparam int unsigned OFF_WAIT_CYC   = OFF_WAIT_MS * CYC_PER_MS + 1;
	localparam int unsigned TOGGLE_CYC     = TOGGLE_HOLD_MS * CYC_PER_MS;
	localparam int unsigned PULSE_HOLD_CYC = PULSE_HOLD_MS * CYC_PER_MS;
	localparam int unsigned LOCK_HOLD_CYC  = LOCK_HOLD_MS * CYC_PER_MS;
	localparam int unsigned CPU1_RST_CYC   = 16;
	localparam int unsigned OS_SHUT_CYC    = 1000;
	localparam int unsigned OS_BOOT_CYC    = 1000;
	// ==========================================
	// pin positions, device side inputs
	localparam int unsigned DIN_W    = 9;
	localparam int unsigned I_CMD    = 0;
	localparam int unsigned I_PWR    = 1;
	localparam int unsigned I_CPU1   = 2;
	localparam int unsigned I_TOG    = 3;
	localparam int unsigned I_MULTI  = 4;
	localparam int unsigned I_COUPLE = 5;
	localparam int unsigned I_REPORT = 6;
	localparam int unsigned I_ALLSTP = 7;
	localparam int unsigned I_CTRLP  = 8;
	// pin positions, host side inputs
	localparam int unsigned HIN_W    = 6;
	localparam int unsigned HI_DONE  = 0;
	localparam int unsigned HI_IND   = 1;
	localparam int unsigned HI_RSTG  = 2;
	localparam int unsigned HI_PEER  = 3;
	localparam int unsigned HI_STERR = 4;
	localparam int unsigned HI_READY = 5;
	// ==========================================
	// pulse width classes
	localparam logic [1:0] WC_NONE  = 2'h0;
	localparam logic [1:0] WC_SHORT = 2'h1;
	localparam logic [1:0] WC_VALID = 2'h2;
	localparam logic [1:0] WC_LOCK  = 2'h3;
	// ==========================================
	// controller registers
	localparam int unsigned ADDR_W   = 8;
	localparam logic [7:0]  REG_CTRL = 8'h00;
	localparam logic [7:0]  REG_CFG  = 8'h04;
	localparam logic [7:0]  REG_STAT = 8'h08;
	localparam logic [7:0]  REG_MASK = 8'h0C;
	localparam logic [7:0]  REG_LIVE = 8'h10;
	localparam int unsigned CT_SHUT  = 0;
	localparam int unsigned CT_PCYC  = 1;
	localparam int unsigned CT_CPU1  = 2;
	localparam int unsigned CT_TOG   = 3;
	localparam int unsigned CT_LOCK  = 4;
	localparam int unsigned CT_POFF  = 5;
	localparam int unsigned CT_PON   = 6;
	localparam int unsigned CFG_W    = 5;
	localparam int unsigned CF_MULTI = 0;
	localparam int unsigned CF_COUPL = 1;
	localparam int unsigned CF_REPRT = 2;
	localparam int unsigned CF_ALLST = 3;
	localparam int unsigned CF_CTRLP = 4;
	localparam logic [4:0]  CFG_RST  = 5'h00;
	localparam int unsigned STAT_W   = 4;
	localparam int unsigned ST_DONE  = 0;
	localparam int unsigned ST_PEER  = 1;
	localparam int unsigned ST_STERR = 2;
	localparam int unsigned ST_SEQ   = 3;
	localparam int unsigned LV_PWR   = 6;
	localparam int unsigned LV_BUSY  = 7;
	// ==========================================
	// states
	typedef enum logic [5:0] {
		D_OFF  = 6'h01,
		D_BOOT = 6'h02,
		D_RUN  = 6'h04,
		D_SHUT = 6'h08,
		D_DONE = 6'h10,
		D_LOCK = 6'h20
	} msrs_dev_state_t;
	typedef enum logic [5:0] {
		H_IDLE  = 6'h01,
		H_HOLD  = 6'h02,
		H_WAITD = 6'h04,
		H_OFF   = 6'h08,
		H_CPU1  = 6'h10,
		H_TOG   = 6'h20
	} msrs_host_state_t;
endpackage
`default_nettype wire

// ### msrs_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface msrs_link_if;
	logic shutdown_cmd;
	logic power_on;
	logic cpu1_reset;
	logic bus_toggle_reset;
	logic multi_cpu;
	logic reset_coupling_switch;
	logic down_report_switch;
	logic all_stop_sel;
	logic ctrl_present;
	logic shutdown_done;
	logic shutdown_done_indicator;
	logic station_resetting;
	logic peer_down_error;
	logic station_error;
	logic os_ready;
	modport dev (
		input  shutdown_cmd, power_on, cpu1_reset, bus_toggle_reset,
		input  multi_cpu, reset_coupling_switch, down_report_switch,
		input  all_stop_sel, ctrl_present,
		output shutdown_done, shutdown_done_indicator, station_resetting,
		output peer_down_error, station_error, os_ready
	);
	modport host (
		output shutdown_cmd, power_on, cpu1_reset, bus_toggle_reset,
		output multi_cpu, reset_coupling_switch, down_report_switch,
		output all_stop_sel, ctrl_present,
		input  shutdown_done, shutdown_done_indicator, station_resetting,
		input  peer_down_error, station_error, os_ready
	);
endinterface
`default_nettype wire

// ### msrs_host_end.sv
`timescale 1ns/10ps
`default_nettype none
module msrs_host_end #(
	parameter int unsigned PULSE_HOLD_CYC = msrs_pkg::PULSE_HOLD_CYC,
	parameter int unsigned LOCK_HOLD_CYC  = msrs_pkg::LOCK_HOLD_CYC,
	parameter int unsigned OFF_WAIT_CYC   = msrs_pkg::OFF_WAIT_CYC,
	parameter int unsigned TOGGLE_CYC     = msrs_pkg::TOGGLE_CYC,
	parameter int unsigned CPU1_RST_CYC   = msrs_pkg::CPU1_RST_CYC
) (
	input  wire logic        i_clk,
	input  wire logic        i_reset,
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_we,
	input  wire logic        i_re,
	output logic      [31:0] o_rdata,
	output logic             o_irq,
	msrs_link_if.host        link
);
	if (PULSE_HOLD_CYC < 1 || LOCK_HOLD_CYC < 1 || OFF_WAIT_CYC < 1 ||
		TOGGLE_CYC < 1 || CPU1_RST_CYC < 1) begin : g_bad_param
		$error("msrs_host_end: timing parameters must be nonzero");
	end

	// ==========================================
	// state
	typedef struct packed {
		logic [msrs_pkg::HIN_W-1:0]   s1;
		logic [msrs_pkg::HIN_W-1:0]   s2;
		logic [msrs_pkg::HIN_W-1:0]   prev;
		logic [msrs_pkg::CFG_W-1:0]   cfg;
		logic [msrs_pkg::STAT_W-1:0]  stat;
		logic [msrs_pkg::STAT_W-1:0]  mask;
		logic [31:0]                  rdata;
		logic                         irq;
		msrs_pkg::msrs_host_state_t   st;
		logic [31:0]                  cnt;
		logic [31:0]                  offcnt;
		logic                         long_hold;
		logic                         pcyc;
		logic                         restarted;
		logic                         cmd;
		logic                         pwr;
		logic                         cpu1;
		logic                         tog;
	} msrs_host_regs_t;

	localparam msrs_host_regs_t HOST_RST = '{
		st: msrs_pkg::H_IDLE, offcnt: 32'(OFF_WAIT_CYC),
		cfg: msrs_pkg::CFG_RST, default: '0};

	msrs_host_regs_t                q, d;
	logic [msrs_pkg::HIN_W-1:0]     rise;
	logic [msrs_pkg::STAT_W-1:0]    ev;
	logic [msrs_pkg::STAT_W-1:0]    clr;
	logic                           off_ok;
	logic                           ctl_wr;

	// ==========================================
	// next state
	always_comb begin
		d = q;
		d.s1[msrs_pkg::HI_DONE]  = link.shutdown_done;
		d.s1[msrs_pkg::HI_IND]   = link.shutdown_done_indicator;
		d.s1[msrs_pkg::HI_RSTG]  = link.station_resetting;
		d.s1[msrs_pkg::HI_PEER]  = link.peer_down_error;
		d.s1[msrs_pkg::HI_STERR] = link.station_error;
		d.s1[msrs_pkg::HI_READY] = link.os_ready;
		d.s2 = q.s1;
		d.prev = q.s2;
		d.rdata = '0;
		rise = q.s2 & ~q.prev;
		ev = '0;
		clr = '0;
		ev[msrs_pkg::ST_DONE] = rise[msrs_pkg::HI_DONE];
		ev[msrs_pkg::ST_PEER] = rise[msrs_pkg::HI_PEER];
		ev[msrs_pkg::ST_STERR] = rise[msrs_pkg::HI_STERR];
		ctl_wr = i_we && i_addr == msrs_pkg::REG_CTRL;
		// power stays off long enough before it returns
		off_ok = q.offcnt >= OFF_WAIT_CYC;
		if (q.pwr)
			d.offcnt = '0;
		else if (!off_ok)
			d.offcnt = q.offcnt + 32'h1;
		// a ready drop with no indicator is an os restart
		if (q.prev[msrs_pkg::HI_READY] && !q.s2[msrs_pkg::HI_READY] &&
			!q.s2[msrs_pkg::HI_IND] && q.pwr)
			d.restarted = 1'b1;
		case (q.st)
			msrs_pkg::H_IDLE: begin
				d.cnt = '0;
				if (q.cfg[msrs_pkg::CF_MULTI] && !q.cfg[msrs_pkg::CF_COUPL] &&
					q.restarted && q.s2[msrs_pkg::HI_READY]) begin
					d.restarted = 1'b0;
					d.cpu1 = 1'b1;
					d.st = msrs_pkg::H_CPU1;
				end else if (rise[msrs_pkg::HI_STERR]) begin
					d.cpu1 = 1'b1;
					d.st = msrs_pkg::H_CPU1;
				end else if (ctl_wr) begin
					if (i_wdata[msrs_pkg::CT_SHUT] ||
						i_wdata[msrs_pkg::CT_PCYC] ||
						i_wdata[msrs_pkg::CT_LOCK]) begin
						d.cmd = 1'b1;
						d.pcyc = i_wdata[msrs_pkg::CT_PCYC];
						d.long_hold = i_wdata[msrs_pkg::CT_LOCK];
						d.st = msrs_pkg::H_HOLD;
					end else if (i_wdata[msrs_pkg::CT_CPU1] ||
						(i_wdata[msrs_pkg::CT_TOG] &&
						q.cfg[msrs_pkg::CF_MULTI])) begin
						d.cpu1 = 1'b1;
						d.st = msrs_pkg::H_CPU1;
					end else if (i_wdata[msrs_pkg::CT_TOG]) begin
						d.tog = 1'b1;
						d.st = msrs_pkg::H_TOG;
					end else if (i_wdata[msrs_pkg::CT_POFF]) begin
						d.pwr = 1'b0;
					end else if (i_wdata[msrs_pkg::CT_PON] && off_ok) begin
						d.pwr = 1'b1;
					end
				end
			end
			msrs_pkg::H_HOLD: begin
				d.cnt = q.cnt + 32'h1;
				if (q.cnt == (q.long_hold ? LOCK_HOLD_CYC - 1 :
					PULSE_HOLD_CYC - 1)) begin
					d.cmd = 1'b0;
					d.cnt = '0;
					d.st = q.pcyc ? msrs_pkg::H_WAITD : msrs_pkg::H_IDLE;
					ev[msrs_pkg::ST_SEQ] = !q.pcyc;
				end
			end
			msrs_pkg::H_WAITD: begin
				if (q.s2[msrs_pkg::HI_DONE]) begin
					d.pwr = 1'b0;
					d.st = msrs_pkg::H_OFF;
				end
			end
			msrs_pkg::H_OFF: begin
				if (off_ok) begin
					d.pwr = 1'b1;
					d.st = msrs_pkg::H_IDLE;
					ev[msrs_pkg::ST_SEQ] = 1'b1;
				end
			end
			msrs_pkg::H_CPU1: begin
				d.cnt = q.cnt + 32'h1;
				if (q.cnt == CPU1_RST_CYC - 1) begin
					d.cpu1 = 1'b0;
					d.st = msrs_pkg::H_IDLE;
					ev[msrs_pkg::ST_SEQ] = 1'b1;
				end
			end
			msrs_pkg::H_TOG: begin
				d.cnt = q.cnt + 32'h1;
				if (q.cnt == TOGGLE_CYC - 1) begin
					d.tog = 1'b0;
					d.st = msrs_pkg::H_IDLE;
					ev[msrs_pkg::ST_SEQ] = 1'b1;
				end
			end
			default: begin
				d.st = msrs_pkg::H_IDLE;
			end
		endcase
		// ==========================================
		// register port
		if (i_we) begin
			case (i_addr)
				msrs_pkg::REG_CFG:  d.cfg = i_wdata[msrs_pkg::CFG_W-1:0];
				msrs_pkg::REG_MASK: d.mask = i_wdata[msrs_pkg::STAT_W-1:0];
				msrs_pkg::REG_STAT: clr = i_wdata[msrs_pkg::STAT_W-1:0];
				default: ;
			endcase
		end
		// a new event beats a clear in the same cycle
		d.stat = (q.stat & ~clr) | ev;
		d.irq = |(d.stat & d.mask);
		if (i_re) begin
			case (i_addr)
				msrs_pkg::REG_CFG:  d.rdata = 32'(q.cfg);
				msrs_pkg::REG_STAT: d.rdata = 32'(q.stat);
				msrs_pkg::REG_MASK: d.rdata = 32'(q.mask);
				msrs_pkg::REG_LIVE: begin
					d.rdata = 32'(q.s2);
					d.rdata[msrs_pkg::LV_PWR] = q.pwr;
					d.rdata[msrs_pkg::LV_BUSY] = q.st != msrs_pkg::H_IDLE;
				end
				default: d.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset)
			q <= HOST_RST;
		else
			q <= d;
	end

	// ==========================================
	// outputs
	assign o_rdata = q.rdata;
	assign o_irq = q.irq;
	assign link.shutdown_cmd = q.cmd;
	assign link.power_on = q.pwr;
	assign link.cpu1_reset = q.cpu1;
	assign link.bus_toggle_reset = q.tog;
	assign link.multi_cpu = q.cfg[msrs_pkg::CF_MULTI];
	assign link.reset_coupling_switch = q.cfg[msrs_pkg::CF_COUPL];
	assign link.down_report_switch = q.cfg[msrs_pkg::CF_REPRT];
	assign link.all_stop_sel = q.cfg[msrs_pkg::CF_ALLST];
	assign link.ctrl_present = q.cfg[msrs_pkg::CF_CTRLP];
endmodule // msrs_host_end
`default_nettype wire

// ### msrs_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module msrs_monitor #(
	parameter int unsigned PULSE_MIN_CYC = 20,
	parameter int unsigned OFF_WAIT_CYC  = 30
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic shutdown_cmd,
	input wire logic power_on,
	input wire logic bus_toggle_reset,
	input wire logic multi_cpu,
	input wire logic down_report_switch,
	input wire logic all_stop_sel,
	input wire logic ctrl_present,
	input wire logic shutdown_done,
	input wire logic shutdown_done_indicator,
	input wire logic station_resetting,
	input wire logic peer_down_error,
	input wire logic os_ready
);
	// ==========================================
	// width counters
	logic [15:0] cmd_q;
	logic [15:0] off_q;
	// off time starts saturated: host takes power-on at once after reset
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			cmd_q <= 16'h0000;
			off_q <= 16'hFFFF;
		end else begin
			cmd_q <= shutdown_cmd ? cmd_q + 16'h0001 : 16'h0000;
			off_q <= power_on ? 16'h0000 :
				(off_q == 16'hFFFF ? off_q : off_q + 16'h0001);
		end
	end
	// ==========================================
	// properties
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	sequence s_lit;
		shutdown_done_indicator && station_resetting;
	endsequence
	property p_min_width;
		$fell(shutdown_cmd) |-> cmd_q >= PULSE_MIN_CYC;
	endproperty
	a_min_width: assert property (p_min_width)
		else $error("command pulse too short");
	property p_off_wait;
		$rose(power_on) |-> off_q >= OFF_WAIT_CYC - 1;
	endproperty
	a_off_wait: assert property (p_off_wait)
		else $error("power back on too soon");
	property p_off_after_done;
		$fell(power_on) |-> $past(shutdown_done);
	endproperty
	a_off_after_done: assert property (p_off_after_done)
		else $error("power removed before completion");
	property p_lit_resets;
		shutdown_done_indicator |-> station_resetting;
	endproperty
	a_lit_resets: assert property (p_lit_resets)
		else $error("indicator lit without resetting");
	property p_done_lit;
		shutdown_done |-> shutdown_done_indicator;
	endproperty
	a_done_lit: assert property (p_done_lit)
		else $error("completion without indicator");
	property p_done_not_ready;
		shutdown_done |-> !os_ready;
	endproperty
	a_done_not_ready: assert property (p_done_not_ready)
		else $error("ready while shut down");
	property p_no_report;
		$rose(peer_down_error) |-> multi_cpu &&
			!(down_report_switch && !all_stop_sel && !ctrl_present);
	endproperty
	a_no_report: assert property (p_no_report)
		else $error("peer error where none is due");
	property p_toggle_single;
		$rose(bus_toggle_reset) |-> !multi_cpu;
	endproperty
	a_toggle_single: assert property (p_toggle_single)
		else $error("bus toggle used in multi rack");
	property p_cmd_lights;
		$fell(shutdown_cmd) && os_ready |-> ##[1:8] s_lit;
	endproperty
	a_cmd_lights: assert property (p_cmd_lights)
		else $error("shutdown did not light indicator");
endmodule // msrs_monitor
`default_nettype wire

// ### msrs_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module msrs_tb_top;
	localparam int PMIN = 20;
	localparam int OFFW = 30;
	localparam int TMO  = 20000;
	localparam int HOLD = 40;
	localparam int LHLD = 80;
	localparam int TOGW = 20;
	localparam int C1W  = 4;
	localparam int LOCKW = 60;
	localparam int SHUTW = 10;
	localparam int BOOTW = 10;
	logic        i_clk = 1'b0;
	logic        i_reset = 1'b1;
	logic        i_we = 1'b0;
	logic        i_re = 1'b0;
	logic        os_rst = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [31:0] d;
	logic        irq;
	logic        lock;
	logic        bif;
	logic        bif_seen = 1'b0;
	logic [1:0]  wcls;
	logic [5:0]  st;
	int          mismatches = 0;
	int          comparisons = 0;
	int          cyc = 0;
	always #2.5 i_clk = ~i_clk;
	msrs_link_if link();
	msrs_host_end #(.PULSE_HOLD_CYC(HOLD), .LOCK_HOLD_CYC(LHLD),
		.OFF_WAIT_CYC(OFFW), .TOGGLE_CYC(TOGW), .CPU1_RST_CYC(C1W))
	msrs_host_end_inst (.i_clk(i_clk), .i_reset(i_reset), .i_addr(addr),
		.i_wdata(wdata), .i_we(i_we), .i_re(i_re), .o_rdata(rdata),
		.o_irq(irq), .link(link));
	msrs_dev_end #(.PULSE_MIN_CYC(PMIN), .LOCKOUT_CYC(LOCKW),
		.SHUT_CYC(SHUTW), .BOOT_CYC(BOOTW))
	msrs_dev_end_inst (.i_clk(i_clk), .i_reset(i_reset),
		.i_os_restart(os_rst), .o_state(st), .o_lockout(lock),
		.o_width_class(wcls), .o_bus_if_reset(bif), .link(link));
	msrs_monitor #(.PULSE_MIN_CYC(PMIN), .OFF_WAIT_CYC(OFFW))
	msrs_monitor_inst (.i_clk(i_clk), .i_reset(i_reset),
		.shutdown_cmd(link.shutdown_cmd), .power_on(link.power_on),
		.bus_toggle_reset(link.bus_toggle_reset),
		.multi_cpu(link.multi_cpu),
		.down_report_switch(link.down_report_switch),
		.all_stop_sel(link.all_stop_sel),
		.ctrl_present(link.ctrl_present),
		.shutdown_done(link.shutdown_done),
		.shutdown_done_indicator(link.shutdown_done_indicator),
		.station_resetting(link.station_resetting),
		.peer_down_error(link.peer_down_error), .os_ready(link.os_ready));
	// ==========================================
	// closing and compares
	task automatic report_and_stop();
		if (mismatches == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch at %0t: reg %h want %h", $time, g, e);
		end
	endtask
	task automatic chk_pin(input logic [5:0] g, input logic [5:0] e);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch at %0t: pin %h want %h", $time, g, e);
		end
	endtask
	// bus pulse is one cycle, so latch it
	always @(posedge i_clk) begin
		cyc++;
		if (bif === 1'b1)
			bif_seen = 1'b1;
		if (cyc == TMO) begin
			mismatches++;
			report_and_stop();
		end
	end
	// ==========================================
	// register port
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge i_clk);
		addr <= a;
		wdata <= v;
		i_we <= 1'b1;
		@(posedge i_clk);
		i_we <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge i_clk);
		addr <= a;
		i_re <= 1'b1;
		@(posedge i_clk);
		i_re <= 1'b0;
		#1 d = rdata;
	endtask
	// bounded poll of one live bit
	task automatic wbit(input int b, input logic v);
		for (int n = 0; n < 400; n++) begin
			rd(msrs_pkg::REG_LIVE);
			if (d[b] === v)
				break;
		end
	endtask
	// controller refuses commands while busy
	task automatic cmd(input logic [31:0] v);
		wr(msrs_pkg::REG_CTRL, v);
		repeat (2) @(posedge i_clk);
		wbit(msrs_pkg::LV_BUSY, 1'b0);
	endtask
	// ==========================================
	// tests
	initial begin
		repeat (5) @(posedge i_clk);
		i_reset <= 1'b0;
		rd(8'h20);
		chk_reg(d, 32'h0);
		wr(msrs_pkg::REG_CFG, 32'h1D);
		wr(msrs_pkg::REG_MASK, 32'h1);
		cmd(32'h40);
		wbit(5, 1'b1);
		@(posedge i_clk) os_rst <= 1'b1;
		@(posedge i_clk) os_rst <= 1'b0;
		wbit(5, 1'b0);
		// let the error-driven first cpu reset finish first
		repeat (6) @(posedge i_clk);
		wr(msrs_pkg::REG_STAT, 32'h8);
		wbit(5, 1'b1);
		wbit(msrs_pkg::LV_BUSY, 1'b0);
		rd(msrs_pkg::REG_STAT);
		chk_pin(6'(d[3:1]), 6'h07);
		wr(msrs_pkg::REG_STAT, 32'hF);
		cmd(32'h02);
		rd(msrs_pkg::REG_STAT);
		chk_pin(6'(d[3:0] & 4'hB), 6'h0B);
		chk_pin(6'(irq), 6'h01);
		chk_pin(6'(wcls), 6'(msrs_pkg::WC_VALID));
		wbit(5, 1'b1);
		wr(msrs_pkg::REG_STAT, 32'hF);
		wr(msrs_pkg::REG_CFG, 32'h03);
		cmd(32'h04);
		repeat (8) @(posedge i_clk);
		chk_pin(st, msrs_pkg::D_DONE);
		cmd(32'h04);
		repeat (8) @(posedge i_clk);
		chk_pin(st, msrs_pkg::D_DONE);
		cmd(32'h20);
		repeat (OFFW + 10) @(posedge i_clk);
		cmd(32'h40);
		wbit(5, 1'b1);
		wr(msrs_pkg::REG_CFG, 32'h0);
		bif_seen = 1'b0;
		cmd(32'h08);
		repeat (8) @(posedge i_clk);
		chk_pin(6'(bif_seen), 6'h01);
		wr(msrs_pkg::REG_CFG, 32'h05);
		wr(msrs_pkg::REG_STAT, 32'hF);
		cmd(32'h10);
		wbit(0, 1'b1);
		chk_pin(6'(lock), 6'h01);
		chk_pin(6'(wcls), 6'(msrs_pkg::WC_LOCK));
		rd(msrs_pkg::REG_STAT);
		chk_pin(6'(d[1]), 6'h00);
		cmd(32'h20);
		repeat (OFFW + 10) @(posedge i_clk);
		cmd(32'h40);
		repeat (30) @(posedge i_clk);
		chk_pin(st, msrs_pkg::D_LOCK);
		chk_pin(6'(lock), 6'h01);
		cmd(32'h01);
		repeat (8) @(posedge i_clk);
		chk_pin(6'(lock), 6'h00);
		report_and_stop();
	end
endmodule // msrs_tb_top
`default_nettype wire
